// File: acp_pkg.sv
/*
 * acp_pkg: constants for the two-wire control port of the audio chip.
 * Assumes a 125 MHz system clock and an external bus master.
 */
// What the document requires of port and master
// R1 - master checks supply-good flags before codec enable
// R2 - DSP data refused for 5 ms after enable
// R3 - master powers converters via codec register zero
// R4 - converter source chosen by codec registers six, seven
// R5 - master sets output volume last
// R6 - master mutes, then switches converters off
// R7 - master clears DSP and codec enables
// R8 - both supply enables cleared powers system down
// R9 - address pair selected by address select pin
// R10 - slave may stretch the bus clock
// R11 - one subaddress byte selects seven registers
// R12 - control subaddress is basic control only
// R13 - words move as two bytes, MSB first
// R14 - subaddresses for both converter config registers
// R15 - DSP read: subaddress, repeated start, NAK, stop
// R16 - reads need repeated start with read address
// R17 - codec write, codec read, DSP write subaddresses
// R18 - clock held low while command is processed
// R19 - config write is address, subaddress, one word
// R20 - master pulses power-on reset before commands
// R21 - direct configuration registers are readable
// R22 - foreign addresses not acknowledged, transfer ignored
package acp_pkg;
    localparam logic [5:0] ADDR_HI = 6'h0F;
    localparam logic [7:0] SUB_DSP_WR = 8'h68;
    localparam logic [7:0] SUB_DSP_RD = 8'h69;
    localparam logic [7:0] SUB_CTRL = 8'h6A;
    localparam logic [7:0] SUB_CODEC_WR = 8'h6C;
    localparam logic [7:0] SUB_CODEC_RD = 8'h6D;
    localparam logic [7:0] SUB_SCONV_CFG = 8'h76;
    localparam logic [7:0] SUB_SCONV_FRQ = 8'h77;
    localparam logic [15:0] CTRL_RESET = 16'h3000;
    localparam logic [15:0] CTRL_WR_MASK = 16'hFF00;
    localparam int CTRL_DC2_BIT = 13;
    localparam int CTRL_DC1_BIT = 12;
    localparam int CTRL_DSP_BIT = 11;
    localparam int CTRL_CODEC_BIT = 10;
    localparam logic [15:0] SCONV_RESET = 16'h0000;
    localparam int SUPPLY_GOOD1_BIT = 15;
    localparam int SUPPLY_GOOD2_BIT = 14;
    localparam int CLK_MHZ = 125;
    localparam int INIT_TIME_MS = 5;
    localparam int INIT_CYCLES = INIT_TIME_MS * 1000 * CLK_MHZ;
    localparam int STRETCH_CYCLES = 4;
    localparam logic [4:0] CODEC_REG_SRC_A = 5'h06;
    localparam logic [4:0] CODEC_REG_SRC_B = 5'h07;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_SUB = 6'b000100,
        ST_WDATA = 6'b001000,
        ST_RDATA = 6'b010000,
        ST_SKIP = 6'b100000
    } acp_state_t;
endpackage

// File: acp_i2c_port.sv
/*
 * acp_i2c_port: two-wire slave with subaddressed 16-bit registers.
 * Assumes raw bus pins, open-drain drivers outside, oe low = drive low.
 */
`timescale 1ns/1ns
`default_nettype none
module acp_i2c_port #(
    parameter int INIT_CYCLES = acp_pkg::INIT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe_n,
    output logic o_sda_oe_n,
    output logic o_scl_o,
    output logic o_sda_o,
    input wire logic i_address_select_pin,
    input wire logic i_supply_good1,
    input wire logic i_supply_good2,
    input wire logic [15:0] i_dsp_rdata,
    input wire logic [15:0] i_codec_rdata,
    output logic [15:0] o_wdata,
    output logic o_dsp_wr,
    output logic o_codec_wr,
    output logic o_dsp_rd,
    output logic o_codec_rd,
    output logic [15:0] o_control,
    output logic [15:0] o_sconv_cfg,
    output logic [15:0] o_sconv_frq,
    output logic o_dsp_ready,
    output logic o_system_power_down
);
    logic [1:0] scl_s_r, sda_s_r;
    logic [1:0] sel_s_r, good1_s_r, good2_s_r;
    logic scl_q_r, sda_q_r;
    always_ff @(posedge i_clk)
    begin
        scl_s_r <= {scl_s_r[0], i_scl};
        sda_s_r <= {sda_s_r[0], i_sda};
        scl_q_r <= scl_s_r[1];
        sda_q_r <= sda_s_r[1];
    end
    // strap and supply flags are pins as well, so they get the same two stages
    always_ff @(posedge i_clk)
    begin
        sel_s_r <= {sel_s_r[0], i_address_select_pin};
        good1_s_r <= {good1_s_r[0], i_supply_good1};
        good2_s_r <= {good2_s_r[0], i_supply_good2};
    end
    wire scl = scl_s_r[1];
    wire sda = sda_s_r[1];
    wire scl_rise = scl & ~scl_q_r;
    wire scl_fall = ~scl & scl_q_r;
    wire start_c = scl & scl_q_r & sda_q_r & ~sda;
    wire stop_c = scl & scl_q_r & ~sda_q_r & sda;

    acp_pkg::acp_state_t state_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r, sub_r;
    logic rd_r, ack_ph_r, hi_byte_r, drive_r, nak_r;
    logic rd_bit_r;
    logic [15:0] tx_r, word_r;
    logic [2:0] str_r;
    logic [31:0] init_r;
    logic [15:0] ctrl_r, cfg_r, frq_r;
    logic [7:0] bcnt_r;

    wire my_addr = (sh_r[7:2] == acp_pkg::ADDR_HI) && (sh_r[1] == sel_s_r[1]); // [R9]
    wire dsp_ok = (init_r == 32'h0) && ctrl_r[acp_pkg::CTRL_CODEC_BIT];

    // unknown subaddresses read as zero rather than stale data
    function automatic logic [15:0] rd_val(input logic [7:0] s, input logic [15:0] d,
                                           input logic [15:0] c);
        unique case (s)
            acp_pkg::SUB_CTRL: rd_val = ctrl_r; // [R21]
            acp_pkg::SUB_SCONV_CFG: rd_val = {good1_s_r[1], good2_s_r[1],
                                              cfg_r[13:0]}; // [R21] [R1]
            acp_pkg::SUB_SCONV_FRQ: rd_val = frq_r; // [R21]
            acp_pkg::SUB_DSP_RD: rd_val = d;
            acp_pkg::SUB_CODEC_RD: rd_val = c;
            default: rd_val = 16'h0000;
        endcase
    endfunction

    // byte engine: address, subaddress, word halves
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_r <= acp_pkg::ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            sub_r <= 8'h00;
            rd_r <= 1'b0;
            ack_ph_r <= 1'b0;
            hi_byte_r <= 1'b1;
            drive_r <= 1'b0;
            nak_r <= 1'b0;
            tx_r <= 16'h0000;
            word_r <= 16'h0000;
        end
        else if (start_c)
        begin
            state_r <= acp_pkg::ST_ADDR;
            bit_r <= 4'h0;
            ack_ph_r <= 1'b0;
            drive_r <= 1'b0;
            hi_byte_r <= 1'b1;
        end
        else if (stop_c)
        begin
            state_r <= acp_pkg::ST_IDLE;
            drive_r <= 1'b0;
        end
        else
        begin
            if (scl_rise && !ack_ph_r && state_r != acp_pkg::ST_RDATA)
            begin
                sh_r <= {sh_r[6:0], sda};
                bit_r <= bit_r + 4'h1;
            end
            if (scl_rise && state_r == acp_pkg::ST_RDATA && !ack_ph_r)
                bit_r <= bit_r + 4'h1;
            if (scl_rise && ack_ph_r && state_r == acp_pkg::ST_RDATA)
                nak_r <= sda; // [R15]
            if (scl_fall)
            begin
                if (bit_r == 4'd8 && !ack_ph_r)
                begin
                    ack_ph_r <= 1'b1;
                    bit_r <= 4'h0;
                    unique case (state_r)
                        acp_pkg::ST_ADDR:
                        begin
                            drive_r <= my_addr; // [R22]
                            rd_r <= sh_r[0];
                            state_r <= my_addr ? (sh_r[0] ? acp_pkg::ST_RDATA
                                : acp_pkg::ST_SUB) : acp_pkg::ST_SKIP; // [R16]
                            tx_r <= rd_val(sub_r, i_dsp_rdata, i_codec_rdata);
                            hi_byte_r <= 1'b1;
                        end
                        acp_pkg::ST_SUB:
                        begin
                            sub_r <= sh_r; // [R11]
                            drive_r <= 1'b1;
                            state_r <= acp_pkg::ST_WDATA;
                        end
                        acp_pkg::ST_WDATA:
                        begin
                            drive_r <= 1'b1;
                            word_r <= {word_r[7:0], sh_r}; // [R13]
                            hi_byte_r <= ~hi_byte_r;
                        end
                        acp_pkg::ST_RDATA:
                        begin
                            drive_r <= 1'b0;
                            hi_byte_r <= ~hi_byte_r;
                            if (!hi_byte_r)
                                tx_r <= rd_val(sub_r, i_dsp_rdata, i_codec_rdata);
                        end
                        default: drive_r <= 1'b0;
                    endcase
                end
                else if (ack_ph_r)
                begin
                    ack_ph_r <= 1'b0;
                    drive_r <= 1'b0;
                    if (state_r == acp_pkg::ST_RDATA && nak_r)
                        state_r <= acp_pkg::ST_SKIP; // [R15]
                end
                else if (state_r == acp_pkg::ST_RDATA)
                    bit_r <= bit_r;
            end
        end
    end

    wire [3:0] tx_idx = hi_byte_r ? 4'd15 - bit_r : 4'd7 - bit_r; // [R13]
    wire word_done = scl_fall && bit_r == 4'd8 && !ack_ph_r && state_r == acp_pkg::ST_WDATA
                     && !hi_byte_r;
    wire rd_word = scl_fall && ack_ph_r && state_r == acp_pkg::ST_RDATA && !hi_byte_r;

    // read data moves only after a clock fall; a change while the clock is
    // high would look like a start or stop to every device on the bus
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            rd_bit_r <= 1'b1;
        else if (scl_fall)
            rd_bit_r <= tx_r[tx_idx]; // [R13]
    end

    // register writes and port strobes
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl_r <= acp_pkg::CTRL_RESET;
            cfg_r <= acp_pkg::SCONV_RESET;
            frq_r <= acp_pkg::SCONV_RESET;
            o_wdata <= 16'h0000;
            o_dsp_wr <= 1'b0;
            o_codec_wr <= 1'b0;
            o_dsp_rd <= 1'b0;
            o_codec_rd <= 1'b0;
        end
        else
        begin
            o_dsp_wr <= 1'b0;
            o_codec_wr <= 1'b0;
            o_dsp_rd <= rd_word && sub_r == acp_pkg::SUB_DSP_RD && dsp_ok;
            o_codec_rd <= rd_word && sub_r == acp_pkg::SUB_CODEC_RD;
            if (word_done)
            begin
                o_wdata <= {word_r[7:0], sh_r};
                unique case (sub_r)
                    acp_pkg::SUB_CTRL: ctrl_r <= {word_r[7:0], sh_r}
                                                 & acp_pkg::CTRL_WR_MASK; // [R12]
                    acp_pkg::SUB_SCONV_CFG: cfg_r <= {word_r[7:0], sh_r}; // [R14]
                    acp_pkg::SUB_SCONV_FRQ: frq_r <= {word_r[7:0], sh_r}; // [R14]
                    acp_pkg::SUB_DSP_WR: o_dsp_wr <= dsp_ok; // [R2] [R17]
                    acp_pkg::SUB_CODEC_WR: o_codec_wr <= 1'b1; // [R17] [R4]
                    default: o_dsp_wr <= 1'b0;
                endcase
            end
        end
    end

    // initialisation timer after codec enable
    // clearing the codec bit restarts the full wait
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || !ctrl_r[acp_pkg::CTRL_CODEC_BIT])
            init_r <= 32'(INIT_CYCLES);
        else if (init_r != 32'h0)
            init_r <= init_r - 32'h1; // [R2]
    end

    // hold clock low while a finished byte is processed
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            str_r <= 3'h0;
        else if (scl_fall && bit_r == 4'd8 && !ack_ph_r && state_r != acp_pkg::ST_SKIP
                 && state_r != acp_pkg::ST_IDLE)
            str_r <= 3'(acp_pkg::STRETCH_CYCLES); // [R10] [R18]
        else if (str_r != 3'h0)
            str_r <= str_r - 3'h1; // [R18]
    end

    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;
    assign o_scl_oe_n = (str_r == 3'h0); // [R18]
    assign o_sda_oe_n = ack_ph_r ? ~drive_r
                      : !(state_r == acp_pkg::ST_RDATA && !rd_bit_r);
    assign o_control = ctrl_r;
    assign o_sconv_cfg = cfg_r;
    assign o_sconv_frq = frq_r;
    assign o_dsp_ready = dsp_ok;
    assign o_system_power_down = !ctrl_r[acp_pkg::CTRL_DC1_BIT]
                               && !ctrl_r[acp_pkg::CTRL_DC2_BIT]; // [R8]

    a_power_down: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R8]
        o_system_power_down == (!o_control[acp_pkg::CTRL_DC2_BIT]
                                && !o_control[acp_pkg::CTRL_DC1_BIT]))
        else $error("power down mismatch");
    a_dsp_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R2]
        o_dsp_wr |-> o_dsp_ready)
        else $error("dsp write before init");
    a_init_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R2]
        $rose(o_control[acp_pkg::CTRL_CODEC_BIT]) |-> !o_dsp_ready [*8])
        else $error("dsp ready too early");
    a_stretch_len: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R18]
        $fell(o_scl_oe_n) |-> !o_scl_oe_n [*4] ##1 o_scl_oe_n)
        else $error("stretch length wrong");
    a_ctrl_low: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
        o_control[7:0] == 8'h00)
        else $error("control low byte set");
    a_no_skip_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R22]
        state_r == acp_pkg::ST_SKIP |-> o_sda_oe_n || $past(ack_ph_r))
        else $error("ack while skipping");
    a_single_wr: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R17]
        !(o_dsp_wr && o_codec_wr))
        else $error("two write strobes");
    a_cfg_write: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
        word_done && sub_r == acp_pkg::SUB_SCONV_FRQ |=> o_sconv_frq == o_wdata)
        else $error("frequency reg not written");
    a_sda_steady: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R13]
        scl && scl_q_r |-> $stable(o_sda_oe_n))
        else $error("data moved while clock high");
    a_dsp_rd_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R2]
        o_dsp_rd |-> o_dsp_ready)
        else $error("dsp read before init");
    a_idle_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R22]
        state_r == acp_pkg::ST_IDLE |-> o_sda_oe_n)
        else $error("data line pulled while idle");
    c_codec_wr: cover property (@(posedge i_clk) o_codec_wr);
    c_dsp_wr: cover property (@(posedge i_clk) o_dsp_wr);
    c_read_word: cover property (@(posedge i_clk) rd_word);
    c_power_down: cover property (@(posedge i_clk) $rose(o_system_power_down));
endmodule
`default_nettype wire

// File: acp_i2c_master.sv
/* acp_i2c_master: behavioural two-wire bus master for the control port.
   Assumes open-drain wiring with pull-ups; an output of 1 releases the line. */
`timescale 1ns/1ns
`default_nettype none
module acp_i2c_master (
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wait_half();
        repeat (16) @(negedge i_clk);
    endtask
    // bounded wait, so a stretched clock that never ends cannot hang
    task automatic scl_high();
        int n;
        o_scl = 1'b1;
        for (n = 0; n < 400 && i_scl !== 1'b1; n++) @(negedge i_clk);
        wait_half();
    endtask
    // hold after the fall, data must not move with the clock edge
    task automatic scl_low();
        o_scl = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic start(); // also the repeated start of a read
        o_sda = 1'b1;
        wait_half();
        scl_high();
        o_sda = 1'b0;
        wait_half();
        scl_low();
    endtask
    task automatic stop();
        o_sda = 1'b0;
        wait_half();
        scl_high();
        o_sda = 1'b1;
        wait_half();
    endtask
    task automatic xfer(input logic b, output logic r);
        o_sda = b;
        wait_half();
        scl_high();
        r = i_sda;
        scl_low();
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask
    // last byte of a read ends with not-acknowledge
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, r);
    endtask
endmodule
`default_nettype wire

// File: tb_audio_chip_i2c_control_port.sv
/* tb_audio_chip_i2c_control_port: random and corner tests of the control port.
   Assumes the port's own assertions and the master model on the bus. */
`timescale 1ns/1ns
`default_nettype none
module tb_audio_chip_i2c_control_port;
    localparam int INIT = 4000;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic sel = 1'h0;
    logic good1 = 1'h0;
    logic good2 = 1'h0;
    logic [15:0] dsp_rdata = 16'h0000;
    logic [15:0] codec_rdata = 16'h0000;
    logic m_scl, m_sda, scl_oe_n, sda_oe_n, a;
    logic dsp_wr, codec_wr, dsp_rd, codec_rd, ready, pdown;
    logic [15:0] wdata, control, cfg, frq, d, r;
    logic [15:0] lfsr = 16'h29B0;
    int fail_count = 0;
    int tests_run = 0;
    int n_dsp_wr = 0;
    int n_codec_rd = 0;
    int n_codec_wr = 0;
    int n_dsp_rd = 0;
    int n_stretch = 0;
    int n0;
    // released lines float high through the pull-ups
    wire scl_w = m_scl & scl_oe_n;
    wire sda_w = m_sda & sda_oe_n;
    always #4 i_clk = ~i_clk;
    acp_i2c_master m (.i_clk(i_clk), .i_scl(scl_w), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
    acp_i2c_port #(.INIT_CYCLES(INIT)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_scl(scl_w), .i_sda(sda_w), .o_scl_oe_n(scl_oe_n), .o_sda_oe_n(sda_oe_n),
        .o_scl_o(), .o_sda_o(), .i_address_select_pin(sel), .i_supply_good1(good1),
        .i_supply_good2(good2), .i_dsp_rdata(dsp_rdata), .i_codec_rdata(codec_rdata),
        .o_wdata(wdata), .o_dsp_wr(dsp_wr), .o_codec_wr(codec_wr), .o_dsp_rd(dsp_rd),
        .o_codec_rd(codec_rd), .o_control(control), .o_sconv_cfg(cfg), .o_sconv_frq(frq),
        .o_dsp_ready(ready), .o_system_power_down(pdown));
    always @(posedge i_clk)
    begin
        if (dsp_wr === 1'b1) n_dsp_wr++;
        if (codec_rd === 1'b1) n_codec_rd++;
        if (codec_wr === 1'b1) n_codec_wr++;
        if (dsp_rd === 1'b1) n_dsp_rd++;
        if (scl_oe_n === 1'b0) n_stretch++;
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] sub, input logic [15:0] v,
                      input logic ack_exp);
        m.start();
        m.put_byte(adr, a);
        chk1(a, ack_exp);
        m.put_byte(sub, a);
        m.put_byte(v[15:8], a);
        m.put_byte(v[7:0], a);
        m.stop();
        repeat (4) @(negedge i_clk);
    endtask
    task automatic rd(input logic [7:0] sub);
        m.start();
        m.put_byte({6'h0F, sel, 1'h0}, a);
        m.put_byte(sub, a);
        m.start();
        m.put_byte({6'h0F, sel, 1'h1}, a);
        chk1(a, 1'h1);
        m.get_byte(1'h0, r[15:8]);
        m.get_byte(1'h1, r[7:0]);
        m.stop();
        repeat (4) @(negedge i_clk);
    endtask
    initial
    begin
        repeat (6) @(posedge i_clk);
        @(negedge i_clk) i_sys_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        chk16(control, acp_pkg::CTRL_RESET);
        chk16(cfg, 16'h0000);
        chk1(pdown, 1'h0);
        for (int s = 0; s < 2; s++)
        begin
            sel = s[0];
            d = rnd();
            wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_SCONV_FRQ, d, 1'h1);
            wr({6'h0F, ~sel, 1'h0}, acp_pkg::SUB_SCONV_FRQ, ~d, 1'h0);
            chk16(frq, d);
            rd(acp_pkg::SUB_SCONV_FRQ);
            chk16(r, d);
            r = rnd();
            {good1, good2} = r[15:14];
            d = rnd();
            wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_SCONV_CFG, d, 1'h1);
            rd(acp_pkg::SUB_SCONV_CFG);
            chk16(r, {good1, good2, d[13:0]});
        end
        rd(acp_pkg::SUB_CTRL);
        chk16(r, acp_pkg::CTRL_RESET);
        rd(8'h70);
        chk16(r, 16'h0000);
        wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_CTRL, 16'h3C00, 1'h1);
        chk16(control, 16'h3C00 & acp_pkg::CTRL_WR_MASK);
        n0 = n_dsp_wr;
        wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_DSP_WR, rnd(), 1'h1);
        chk1(n_dsp_wr == n0 && ready === 1'h0, 1'h1);
        repeat (INIT) @(negedge i_clk);
        chk1(ready, 1'h1);
        d = rnd();
        wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_DSP_WR, d, 1'h1);
        chk1(n_dsp_wr == n0 + 1, 1'h1);
        chk16(wdata, d);
        // power on, sources, volume, mute, power off
        for (int i = 0; i < 5; i++)
        begin
            d = (i == 1) ? 16'h0006 : (i == 2) ? 16'h0007 : (i == 3) ? 16'h0010 : rnd();
            wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_CODEC_WR, d, 1'h1);
            chk16(wdata, d);
            chk1(n_codec_wr == i + 1, 1'h1);
        end
        codec_rdata = rnd();
        rd(acp_pkg::SUB_CODEC_RD);
        chk16(r, codec_rdata);
        chk1(n_codec_rd > 0, 1'h1);
        dsp_rdata = rnd();
        rd(acp_pkg::SUB_DSP_RD);
        chk16(r, dsp_rdata);
        chk1(n_dsp_rd == 1, 1'h1);
        wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_CTRL, 16'h3000, 1'h1);
        chk1(ready, 1'h0);
        wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_CTRL, 16'h0000, 1'h1);
        chk1(pdown, 1'h1);
        wr({6'h0F, sel, 1'h0}, acp_pkg::SUB_CTRL, 16'h1000, 1'h1);
        chk1(pdown, 1'h0);
        chk1(n_stretch > 0, 1'h1);
        end_sim();
    end
    initial
    begin
        repeat (80000) @(posedge i_clk);
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
